//--- src/disp_pkg.sv
// shared constants, types and helpers of the rgb display timing output
`default_nettype none
package disp_pkg;
  localparam int ADDR_W = 8;
  localparam int PIX_W = 24;
  localparam int TIM_W = 12;
  localparam int POS_W = 14;
  localparam int INT_W = 3;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_HTIM_A = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_HTIM_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_VTIM_A = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_VTIM_B = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_FRAME_CNT = 8'h20;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DE_HIGH_BIT = 1;
  localparam int CTRL_VS_HIGH_BIT = 2;
  localparam int CTRL_HS_HIGH_BIT = 3;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_FMT_LSB = 8;
  localparam int FLD_LO_LSB = 0;
  localparam int FLD_HI_LSB = 16;
  localparam int STAT_HPOS_LSB = 0;
  localparam int STAT_VPOS_LSB = 16;
  localparam int STAT_ACTIVE_BIT = 30;
  localparam int STAT_EMPTY_BIT = 31;
  localparam int INT_UNDERRUN_BIT = 0;
  localparam int INT_FRAME_BIT = 1;
  localparam int INT_VBLANK_BIT = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_000E;
  localparam logic [31:0] HTIM_A_RST = 32'h000A_0500;
  localparam logic [31:0] HTIM_B_RST = 32'h0046_0050;
  localparam logic [31:0] VTIM_A_RST = 32'h0003_0320;
  localparam logic [31:0] VTIM_B_RST = 32'h000A_000A;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

  typedef enum logic [1:0] {
    FMT_24 = 2'b00,
    FMT_18 = 2'b01,
    FMT_16 = 2'b10
  } pix_fmt_e;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_BACK = 2'b01,
    SEG_ACTIVE = 2'b10,
    SEG_FRONT = 2'b11
  } seg_e;

  function automatic logic [POS_W-1:0] ext(input logic [TIM_W-1:0] v);
    return {{(POS_W-TIM_W){1'b0}}, v};
  endfunction : ext

  function automatic logic [POS_W-1:0] period_of(input logic [TIM_W-1:0] act,
      input logic [TIM_W-1:0] syncW, input logic [TIM_W-1:0] back,
      input logic [TIM_W-1:0] front);
    return ext(act) + ext(syncW) + ext(back) + ext(front);
  endfunction : period_of

  // sync first, then back porch, active, front porch
  function automatic seg_e seg_of(input logic [POS_W-1:0] pos,
      input logic [TIM_W-1:0] syncW, input logic [TIM_W-1:0] back,
      input logic [TIM_W-1:0] act);
    if (pos < ext(syncW)) return SEG_SYNC;
    if (pos < ext(syncW) + ext(back)) return SEG_BACK;
    if (pos < ext(syncW) + ext(back) + ext(act)) return SEG_ACTIVE;
    return SEG_FRONT;
  endfunction : seg_of

  // narrower panels take the top bits of each component, packed low
  function automatic logic [PIX_W-1:0] colour_convert(input logic [PIX_W-1:0] rgb,
      input logic [1:0] fmt);
    case (fmt)
      FMT_18: return {6'h00, rgb[23:18], rgb[15:10], rgb[7:2]};
      FMT_16: return {8'h00, rgb[23:19], rgb[15:10], rgb[7:3]};
      default: return rgb;
    endcase
  endfunction : colour_convert
endpackage : disp_pkg
`default_nettype wire

//--- src/pix_fifo_if.sv
// pixel fifo fill and drain signals
`default_nettype none
interface pix_fifo_if;
  import disp_pkg::*;
  logic pushValid;
  logic pushReady;
  logic [PIX_W-1:0] pushData;
  logic popReq;
  logic [PIX_W-1:0] popData;
  logic empty;
  modport store(input pushValid, input pushData, input popReq,
    output pushReady, output popData, output empty);
  modport user(output pushValid, output pushData, output popReq,
    input pushReady, input popData, input empty);
endinterface : pix_fifo_if
`default_nettype wire

//--- src/bit_sync.sv
// two flip-flop level synchroniser
`default_nettype none
module bit_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic first;
    logic second;
  } sync_s;
  sync_s state_ff;
  sync_s nxt_state;

  always_comb begin
    nxt_state.first = din;
    nxt_state.second = state_ff.first;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign dout = state_ff.second;
endmodule : bit_sync
`default_nettype wire

//--- src/pixel_fifo.sv
// pixel fifo in flip-flops, one clock
`default_nettype none
module pixel_fifo
  import disp_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  pix_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][PIX_W-1:0] mem;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } fifo_s;
  fifo_s state_ff;
  fifo_s nxt_state;
  logic full;

  assign full = (state_ff.wrPtr[AW] != state_ff.rdPtr[AW])
    && (state_ff.wrPtr[AW-1:0] == state_ff.rdPtr[AW-1:0]);
  assign port.empty = state_ff.wrPtr == state_ff.rdPtr;
  assign port.pushReady = ~full;
  assign port.popData = state_ff.mem[state_ff.rdPtr[AW-1:0]];

  always_comb begin
    nxt_state = state_ff;
    if (port.pushValid && !full) begin
      nxt_state.mem[state_ff.wrPtr[AW-1:0]] = port.pushData;
      nxt_state.wrPtr = state_ff.wrPtr + 1'b1;
    end
    if (port.popReq && !port.empty) begin
      nxt_state.rdPtr = state_ff.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule : pixel_fifo
`default_nettype wire

//--- src/rgb_display_timing_output.sv
// rgb display timing output: apb registers, raster timing, pixel launch
// Function
// R1 - one whole rgb pixel leaves in parallel per active pixel clock
// R2 - output width selectable as 24, 18 or 16 bits per pixel
// R3 - each active pixel edge pops the fifo, converts format, drives the bus
// R4 - horizontal timing in pixel clocks, vertical timing in lines, all programmable
// R5 - vertical sync marks the start of every frame
// R6 - horizontal sync marks the start of every line
// R7 - data enable only on cycles carrying active pixels, off in blanking
// R8 - 24-bit colour bus plus an output pixel clock for sampling
// R9 - only pixel clock, syncs, enable and colour are driven here
// R10 - these outputs feed the serial host parallel input when routed
// R11 - enable, vsync, hsync polarity and launch edge set independently
// R12 - any pixel to bus clock ratio via the fifo; underrun is an error; the bus clock samples the pixel clock, which must stay under half of it
// R13 - one common clock for registers and pixel source
// R14 - partner input clock runs at pixel clock rate in pass-through
// R15 - frame lasts vertical period times horizontal period pixel clocks
// R16 - partner lane bit clock must exceed pixel clock times bpp over lanes
// R17 - line and frame order: sync, back porch, active, front porch
// R18 - periods are sums of active, sync, back and front porch
//
// The implementer's own choices: the address map and the APB register port.
`default_nettype none
module rgb_display_timing_output
  import disp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pixelValid,
  input wire logic [PIX_W-1:0] pixelData,
  output logic pixelReady,
  input wire logic pixelClockIn,
  output logic panelPixelClockOut,
  output logic vsyncOut,
  output logic hsyncOut,
  output logic dataEnableOut,
  output logic [PIX_W-1:0] colourDataBus,
  output logic irq
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] hTimA;
    logic [31:0] hTimB;
    logic [31:0] vTimA;
    logic [31:0] vTimB;
    logic [INT_W-1:0] intStat;
    logic [INT_W-1:0] intMask;
    logic [31:0] frameCnt;
    logic [31:0] rdData;
    logic slvErr;
    logic clkPrev;
    logic [POS_W-1:0] hPos;
    logic [POS_W-1:0] vPos;
    logic vsyncPhys;
    logic hsyncPhys;
    logic dePhys;
    logic [PIX_W-1:0] colour;
  } top_s;

  top_s state_ff;
  top_s nxt_state;

  pix_fifo_if fifoIf ();

  logic pixSync;
  logic riseTick;
  logic fallTick;
  logic tick;
  logic enabled;
  logic setupPhase;
  logic wrAccess;
  logic [TIM_W-1:0] hWidth;
  logic [TIM_W-1:0] hSyncW;
  logic [TIM_W-1:0] hBack;
  logic [TIM_W-1:0] hFront;
  logic [TIM_W-1:0] vHeight;
  logic [TIM_W-1:0] vSyncW;
  logic [TIM_W-1:0] vBack;
  logic [TIM_W-1:0] vFront;
  logic [POS_W-1:0] hPeriod;
  logic [POS_W-1:0] vPeriod;
  seg_e hSeg;
  seg_e vSeg;
  logic activePix;
  logic underrun;
  logic frameStart;
  logic vblankStart;
  logic [INT_W-1:0] events;

  // pixel clock arrives from another domain: two flops before any use
  bit_sync pixClkSync (
    .clock(clock),
    .rst_n(rst_n),
    .din(pixelClockIn),
    .dout(pixSync)
  );

  pixel_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) pixFifo (
    .clock(clock),
    .rst_n(rst_n),
    .port(fifoIf.store)
  );

  // the pixel source shares the register clock, so no crossing here
  assign fifoIf.pushValid = pixelValid; // [R13]
  assign fifoIf.pushData = pixelData;
  assign pixelReady = fifoIf.pushReady; // [R12]

  // field decode of the timing registers
  assign hWidth = state_ff.hTimA[FLD_LO_LSB +: TIM_W]; // [R4]
  assign hSyncW = state_ff.hTimA[FLD_HI_LSB +: TIM_W];
  assign hBack = state_ff.hTimB[FLD_LO_LSB +: TIM_W];
  assign hFront = state_ff.hTimB[FLD_HI_LSB +: TIM_W];
  assign vHeight = state_ff.vTimA[FLD_LO_LSB +: TIM_W];
  assign vSyncW = state_ff.vTimA[FLD_HI_LSB +: TIM_W];
  assign vBack = state_ff.vTimB[FLD_LO_LSB +: TIM_W];
  assign vFront = state_ff.vTimB[FLD_HI_LSB +: TIM_W];
  assign hPeriod = period_of(hWidth, hSyncW, hBack, hFront); // [R18]
  assign vPeriod = period_of(vHeight, vSyncW, vBack, vFront); // [R18]

  // launch edge choice; the edge detector reads only the synced copy
  assign riseTick = pixSync & ~state_ff.clkPrev;
  assign fallTick = ~pixSync & state_ff.clkPrev;
  assign tick = state_ff.ctrl[CTRL_FALL_BIT] ? fallTick : riseTick; // [R11]

  // a zero period would wrap on every tick and hold the position at zero, so it counts as disabled
  assign enabled = state_ff.ctrl[CTRL_EN_BIT] && (hPeriod != '0) && (vPeriod != '0);

  assign hSeg = seg_of(state_ff.hPos, hSyncW, hBack, hWidth); // [R17]
  assign vSeg = seg_of(state_ff.vPos, vSyncW, vBack, vHeight); // [R17]
  assign activePix = (hSeg == SEG_ACTIVE) && (vSeg == SEG_ACTIVE);

  assign fifoIf.popReq = tick & enabled & activePix & ~fifoIf.empty; // [R3]
  assign underrun = tick & enabled & activePix & fifoIf.empty; // [R12]
  assign frameStart = tick & enabled & (state_ff.hPos == '0) & (state_ff.vPos == '0);
  assign vblankStart = tick & enabled & (state_ff.hPos == '0)
    & (state_ff.vPos == ext(vSyncW) + ext(vBack) + ext(vHeight));

  always_comb begin
    events = '0;
    events[INT_UNDERRUN_BIT] = underrun;
    events[INT_FRAME_BIT] = frameStart;
    events[INT_VBLANK_BIT] = vblankStart;
  end

  // zero wait states: the access phase always ends on its first cycle
  assign setupPhase = psel & ~penable;
  assign wrAccess = psel & penable & pwrite & pready;
  assign pready = 1'b1;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.clkPrev = pixSync;

    // read data and error are captured in the setup cycle
    if (setupPhase) begin
      nxt_state.rdData = '0;
      nxt_state.slvErr = 1'b0;
      case (paddr)
        OFS_CTRL: nxt_state.rdData = state_ff.ctrl;
        OFS_HTIM_A: nxt_state.rdData = state_ff.hTimA;
        OFS_HTIM_B: nxt_state.rdData = state_ff.hTimB;
        OFS_VTIM_A: nxt_state.rdData = state_ff.vTimA;
        OFS_VTIM_B: nxt_state.rdData = state_ff.vTimB;
        OFS_STATUS: begin
          nxt_state.rdData[STAT_HPOS_LSB +: POS_W] = state_ff.hPos;
          nxt_state.rdData[STAT_VPOS_LSB +: POS_W] = state_ff.vPos;
          nxt_state.rdData[STAT_ACTIVE_BIT] = enabled & activePix;
          nxt_state.rdData[STAT_EMPTY_BIT] = fifoIf.empty;
        end
        OFS_INT_STAT: nxt_state.rdData[INT_W-1:0] = state_ff.intStat;
        OFS_INT_MASK: nxt_state.rdData[INT_W-1:0] = state_ff.intMask;
        OFS_FRAME_CNT: nxt_state.rdData = state_ff.frameCnt;
        default: nxt_state.slvErr = 1'b1;
      endcase
    end

    if (wrAccess) begin
      case (paddr)
        OFS_CTRL: nxt_state.ctrl = pwdata;
        OFS_HTIM_A: nxt_state.hTimA = pwdata;
        OFS_HTIM_B: nxt_state.hTimB = pwdata;
        OFS_VTIM_A: nxt_state.vTimA = pwdata;
        OFS_VTIM_B: nxt_state.vTimB = pwdata;
        OFS_INT_MASK: nxt_state.intMask = pwdata[INT_W-1:0];
        default: ;
      endcase
    end

    // write one to clear; a new event in the same cycle stays set
    if (wrAccess && paddr == OFS_INT_STAT) begin
      nxt_state.intStat = state_ff.intStat & ~pwdata[INT_W-1:0];
    end
    nxt_state.intStat = nxt_state.intStat | events; // [R12]

    if (frameStart) begin
      nxt_state.frameCnt = state_ff.frameCnt + 32'h0000_0001;
    end

    if (!enabled) begin
      // restart from the top of the frame; syncs, enable and colour idle
      nxt_state.hPos = '0;
      nxt_state.vPos = '0;
      // idle levels take a polarity written this cycle, so no stale active level at enable
      nxt_state.vsyncPhys = 1'b0 ~^ nxt_state.ctrl[CTRL_VS_HIGH_BIT]; // [R11]
      nxt_state.hsyncPhys = 1'b0 ~^ nxt_state.ctrl[CTRL_HS_HIGH_BIT]; // [R11]
      nxt_state.dePhys = 1'b0 ~^ nxt_state.ctrl[CTRL_DE_HIGH_BIT]; // [R7]
      nxt_state.colour = '0;
    end else if (tick) begin
      // one pixel clock: emit the current position, then step on
      nxt_state.vsyncPhys = (vSeg == SEG_SYNC) ~^ state_ff.ctrl[CTRL_VS_HIGH_BIT]; // [R5] [R11]
      nxt_state.hsyncPhys = (hSeg == SEG_SYNC) ~^ state_ff.ctrl[CTRL_HS_HIGH_BIT]; // [R6] [R11]
      nxt_state.dePhys = activePix ~^ state_ff.ctrl[CTRL_DE_HIGH_BIT]; // [R7] [R11]
      if (activePix) begin
        // an underrun shows black rather than stale data
        nxt_state.colour = fifoIf.empty ? '0 :
          colour_convert(fifoIf.popData, state_ff.ctrl[CTRL_FMT_LSB +: 2]); // [R1] [R2] [R3]
      end else begin
        nxt_state.colour = '0;
      end
      if (state_ff.hPos + 1'b1 >= hPeriod) begin
        nxt_state.hPos = '0; // [R15]
        if (state_ff.vPos + 1'b1 >= vPeriod) begin
          nxt_state.vPos = '0; // [R15]
        end else begin
          nxt_state.vPos = state_ff.vPos + 1'b1;
        end
      end else begin
        nxt_state.hPos = state_ff.hPos + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
      state_ff.ctrl <= CTRL_RST;
      state_ff.hTimA <= HTIM_A_RST;
      state_ff.hTimB <= HTIM_B_RST;
      state_ff.vTimA <= VTIM_A_RST;
      state_ff.vTimB <= VTIM_B_RST;
      state_ff.intMask <= INT_MASK_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // the output clock follows the sampled clock, data change with the launch edge
  assign panelPixelClockOut = state_ff.clkPrev; // [R8] [R10]
  assign vsyncOut = state_ff.vsyncPhys; // [R9] [R10]
  assign hsyncOut = state_ff.hsyncPhys; // [R9] [R10]
  assign dataEnableOut = state_ff.dePhys; // [R9] [R10]
  assign colourDataBus = state_ff.colour; // [R8] [R10]
  assign prdata = state_ff.rdData;
  assign pslverr = state_ff.slvErr;
  assign irq = |(state_ff.intStat & state_ff.intMask);
endmodule : rgb_display_timing_output
`default_nettype wire

//--- verif/rgb_display_timing_output_monitor.sv
// port-level assertions for the rgb display timing output
`default_nettype none
module rgb_display_timing_output_monitor
  import disp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic pixelClockIn,
  input wire logic panelPixelClockOut,
  input wire logic vsyncOut,
  input wire logic hsyncOut,
  input wire logic dataEnableOut,
  input wire logic [PIX_W-1:0] colourDataBus,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadows of ctrl and mask; outputs trusted 3 cycles after a ctrl write
  logic [31:0] shCtrl_ff;
  logic [INT_W-1:0] shMask_ff;
  logic [1:0] quiet_ff;
  logic wrEdge, steady, vsAct, hsAct;
  assign wrEdge = psel && penable && pwrite;
  assign steady = shCtrl_ff[CTRL_EN_BIT] && quiet_ff == 2'h3;
  assign vsAct = vsyncOut == shCtrl_ff[CTRL_VS_HIGH_BIT];
  assign hsAct = hsyncOut == shCtrl_ff[CTRL_HS_HIGH_BIT];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shCtrl_ff <= CTRL_RST;
      shMask_ff <= INT_MASK_RST;
      quiet_ff <= 2'h0;
    end else begin
      if (wrEdge && paddr == OFS_CTRL) begin
        shCtrl_ff <= pwdata;
        quiet_ff <= 2'h0;
      end else if (quiet_ff != 2'h3) begin
        quiet_ff <= quiet_ff + 2'h1;
      end
      if (wrEdge && paddr == OFS_INT_MASK) begin
        shMask_ff <= pwdata[INT_W-1:0];
      end
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > OFS_FRAME_CNT)) else $error("error response wrong");
  chk_irq_masked: assert property (irq |-> shMask_ff != 3'h0)
    else $error("irq with all masked");
  chk_blank_colour: assert property (steady && colourDataBus != 24'h0
    |-> dataEnableOut == shCtrl_ff[CTRL_DE_HIGH_BIT]) else $error("colour outside enable");
  chk_launch_edge: assert property (steady && ($changed(colourDataBus)
    || $changed(hsyncOut) || $changed(vsyncOut) || $changed(dataEnableOut))
    |-> $changed(panelPixelClockOut) && panelPixelClockOut != shCtrl_ff[CTRL_FALL_BIT])
    else $error("output moved off launch edge");
  chk_clock_follow: assert property (steady
    |-> panelPixelClockOut == $past(pixelClockIn, 3)) else $error("pixel clock lag");
  chk_frame_line: assert property (steady && $rose(vsAct) |-> $rose(hsAct))
    else $error("frame start without line start");
  chk_fmt_eighteen: assert property (steady && shCtrl_ff[9:8] == 2'h1
    |-> colourDataBus[23:18] == 6'h00) else $error("18 bpp upper bits set");
  chk_fmt_sixteen: assert property (steady && shCtrl_ff[9:8] == 2'h2
    |-> colourDataBus[23:16] == 8'h00) else $error("16 bpp upper bits set");
  cover property (steady && $rose(vsAct));
  cover property ($rose(irq));
  cover property (psel && penable && pslverr);
endmodule : rgb_display_timing_output_monitor
bind rgb_display_timing_output rgb_display_timing_output_monitor #(.FIFO_DEPTH(FIFO_DEPTH))
  mon (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .pixelClockIn,
  .panelPixelClockOut, .vsyncOut, .hsyncOut, .dataEnableOut, .colourDataBus, .irq);
`default_nettype wire

//--- verif/panel_model.sv
// panel side: free pixel clock source and raster sampler
`default_nettype none
module panel_model
  import disp_pkg::*;
(
  input wire logic clr,
  input wire logic [3:0] lvl,
  input wire logic panelPixelClockOut,
  input wire logic vsyncOut,
  input wire logic hsyncOut,
  input wire logic dataEnableOut,
  input wire logic [PIX_W-1:0] colourDataBus,
  output logic pixelClockIn,
  output int ticks,
  output int deCnt,
  output int hsCnt,
  output int vsCnt,
  output int firstDe,
  output logic [PIX_W-1:0] lastPix
);
  timeunit 1ns;
  timeprecision 1ps;
  // a serial host behind this port keeps its bit period under lanes * 200 ns / 24 bits
  localparam int LANES = 2;
  localparam int LANE_BIT_NS = 4;
  // offset keeps its edges clear of system clock edges
  initial begin
    pixelClockIn = 1'b0;
    #7;
    forever #100 pixelClockIn = ~pixelClockIn;
  end
  // sample on the edge opposite the launch edge; lvl is {fall,hs,vs,de}
  always @(panelPixelClockOut or posedge clr) begin
    if (clr) begin
      ticks = 0;
      deCnt = 0;
      hsCnt = 0;
      vsCnt = 0;
      firstDe = -1;
      lastPix = 24'hFFFFFF;
    end else if (panelPixelClockOut == lvl[3]) begin
      if (dataEnableOut == lvl[0]) begin
        if (firstDe < 0) firstDe = ticks;
        deCnt++;
        lastPix = colourDataBus;
      end
      hsCnt += int'(hsyncOut == lvl[2]);
      vsCnt += int'(vsyncOut == lvl[1]);
      ticks++;
    end
  end
endmodule : panel_model
`default_nettype wire

//--- verif/rgb_display_timing_output_test.sv
// self-checking bench for the rgb display timing output
`default_nettype none
module rgb_display_timing_output_test
  import disp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pixelReady, pixelClockIn, panelPixelClockOut;
  logic vsyncOut, hsyncOut, dataEnableOut, irq;
  logic clr = 1'b0;
  logic pixelValid = 1'b1;
  logic [PIX_W-1:0] pixelData = 24'hA5C3E7;
  logic [PIX_W-1:0] colourDataBus, lastPix;
  logic [3:0] lvl = 4'h7;
  int ticks, deCnt, hsCnt, vsCnt, firstDe;
  int nErrors = 0;
  int totalChecks = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  rgb_display_timing_output #(.FIFO_DEPTH(16)) dut (.clock, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pixelValid, .pixelData,
    .pixelReady, .pixelClockIn, .panelPixelClockOut, .vsyncOut, .hsyncOut, .dataEnableOut,
    .colourDataBus, .irq);
  panel_model panel (.clr, .lvl, .panelPixelClockOut, .vsyncOut, .hsyncOut, .dataEnableOut,
    .colourDataBus, .pixelClockIn, .ticks, .deCnt, .hsCnt, .vsCnt, .firstDe, .lastPix);
  task automatic results();
    if (nErrors == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic clear();
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask : clear
  task automatic frameStart(input logic l);
    wait (vsyncOut !== l);
    wait (vsyncOut === l);
  endtask : frameStart
  task automatic waitIrq();
    for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clock);
    chk("irq raised", 32'h1, irq);
  endtask : waitIrq
  task automatic t_regs();
    logic [ADDR_W-1:0] ofs [5] = '{OFS_CTRL, OFS_HTIM_A, OFS_HTIM_B, OFS_VTIM_A, OFS_VTIM_B};
    logic [31:0] rv [5] = '{CTRL_RST, HTIM_A_RST, HTIM_B_RST, VTIM_A_RST, VTIM_B_RST};
    logic [31:0] cfg [5] = '{32'h0, 32'h0002_0004, 32'h0001_0001, 32'h0001_0002, 32'h0001_0001};
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0, q, e);
      chk("reset value", rv[i], q);
      wr(ofs[i], cfg[i]);
      apb(1'b0, ofs[i], 32'h0, q, e);
      chk("timing readback", cfg[i], q);
    end
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped error", 32'h1, e);
    chk("fifo full stall", 32'h0, pixelReady);
  endtask : t_regs
  // raster 8 x 5 ticks: width 4, hsync 2, porches 1; height 2, vsync 1, porches 1
  task automatic t_frame(input logic [31:0] ctrl, input logic [PIX_W-1:0] pix);
    logic [31:0] q0;
    logic [31:0] q;
    logic e;
    wr(OFS_CTRL, 32'h0);
    lvl <= ctrl[4:1];
    wr(OFS_CTRL, ctrl);
    frameStart(ctrl[2]);
    clear();
    apb(1'b0, OFS_FRAME_CNT, 32'h0, q0, e);
    frameStart(ctrl[2]);
    chk("ticks per frame", 32'h28, ticks);
    chk("enable ticks", 32'h8, deCnt);
    chk("hsync ticks", 32'hA, hsCnt);
    chk("vsync ticks", 32'h8, vsCnt);
    chk("first enable tick", 32'h13, firstDe);
    chk("pixel value", pix, lastPix);
    apb(1'b0, OFS_FRAME_CNT, 32'h0, q, e);
    chk("frame count", q0 + 32'h1, q);
  endtask : t_frame
  task automatic t_irq();
    logic [31:0] q;
    logic e;
    pixelValid <= 1'b0;
    wr(OFS_INT_MASK, 32'h1);
    waitIrq();
    chk("fifo ready", 32'h1, pixelReady);
    apb(1'b0, OFS_INT_STAT, 32'h0, q, e);
    chk("underrun flag", 32'h1, {31'h0, q[INT_UNDERRUN_BIT]});
    frameStart(1'b1);
    clear();
    frameStart(1'b1);
    chk("underrun colour", 32'h0, lastPix);
    chk("underrun enable", 32'h8, deCnt);
    wr(OFS_INT_MASK, 32'h0);
    @(negedge clock);
    chk("irq masked", 32'h0, irq);
    wr(OFS_INT_STAT, 32'h7);
    wr(OFS_INT_MASK, 32'h2);
    waitIrq();
    wr(OFS_INT_STAT, 32'h2);
    @(negedge clock);
    chk("irq cleared", 32'h0, irq);
  endtask : t_irq
  // hang guard, well above the roughly 3400 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_frame(32'h0000_0001, 24'hA5C3E7);
    t_frame(32'h0000_000F, 24'hA5C3E7);
    t_frame(32'h0000_010F, 24'h029C39);
    t_frame(32'h0000_020F, 24'h00A61C);
    t_frame(32'h0000_031F, 24'hA5C3E7);
    t_irq();
    results();
  end
endmodule : rgb_display_timing_output_test
`default_nettype wire
